// >>> logic/rusp_dev.sv
// Device end: setting store with busy handshake, reload and watchdog
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ns
// Summary of operation
// - Everything happens on rising clock edge
// - Reset acts asynchronously, restores initial state
// - Controller resets block before first request
// - Reset aborts a write in progress
// - Reload trigger when idle starts reconfiguration
// - Reload trigger ignored while busy
// - Watchdog restart clears timer even busy
// - Unconnected optional inputs default to zero; no input here declares a default, so every input must be driven
// - Read raises busy, select ignored meanwhile
// - Controller waits busy low before next read
// - Write stores value into selected setting
// - Controller pulses write request one cycle
// - Busy held through write, buses ignored
// - Controller waits busy low before next write
// - Writes only in factory image
// - Select is a 3-bit bus
// - Write value 12 bits, low bits used
// - Write value captured with request
// - Busy high until operation completes
// - Read value valid after busy falls
// - Index zero returns read-only status
module rusp_dev #(
    parameter int WDOG_W = 12
) (
    // Clock
    input wire logic I_CLK,
    // Setting port
    rusp_if.dev port,
    // Device context
    input wire logic I_FACTORY,
    input wire logic [rusp_pkg::STAT_W-1:0] I_CAUSE,
    input wire logic I_WDOG_EN,
    // Device actions
    output logic O_RECONFIG,
    output logic O_WDOG_EXPIRE,
    output logic [WDOG_W-1:0] O_WDOG_CNT
);
    import rusp_pkg::*;

    // ========================================
    // Access sequencer state
    rusp_state_t state_r;
    rusp_state_t state_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [SEL_W-1:0] sel_r;
    logic [SEL_W-1:0] sel_nxt;
    logic [VAL_W-1:0] val_r;
    logic [VAL_W-1:0] val_nxt;
    logic busy_r;
    logic busy_nxt;
    logic [VAL_W-1:0] rval_r;
    logic [VAL_W-1:0] rval_nxt;

    // ========================================
    // Setting store and status
    logic [VAL_W-1:0] set_r [NSET];
    logic [STAT_W-1:0] stat_r;

    // ========================================
    // Reload and watchdog state
    logic recfg_r;
    logic recfg_nxt;
    logic [WDOG_W-1:0] wdog_r;
    logic [WDOG_W-1:0] wdog_nxt;
    logic wexp_r;
    logic wexp_nxt;

    // ========================================
    // Decode
    // Index zero is the read-only status; every other index is a store
    function automatic logic is_store(input logic [SEL_W-1:0] idx);
        return (idx != SEL_STATUS);
    endfunction

    wire logic idle = (state_r == RUSP_IDLE);
    wire logic in_read = (state_r == RUSP_READ);
    wire logic in_write = (state_r == RUSP_WRITE);
    wire logic take_rd = idle && port.read_req;
    wire logic take_wr = idle && !port.read_req && port.write_req && I_FACTORY;
    wire logic take = take_rd || take_wr;
    wire logic done = !idle && (cnt_r == ACC_LAST);
    wire logic rd_done = done && in_read;
    wire logic wr_done = done && in_write && is_store(sel_r);
    wire logic [VAL_W-1:0] stat_word = {{(VAL_W-STAT_W){1'b0}}, stat_r};
    wire logic [VAL_W-1:0] rd_word = is_store(sel_r) ? set_r[sel_r] : stat_word;

    // ========================================
    // Next values
    // Busy follows the state, so it falls on the edge the result lands
    assign busy_nxt = (state_nxt != RUSP_IDLE);
    // Operands latched only at the request; the buses are free afterwards
    assign sel_nxt = take ? port.sel : sel_r;
    assign val_nxt = take ? port.wval : val_r;
    assign cnt_nxt = take ? CNT_ZERO : (idle ? cnt_r : cnt_r + CNT_ONE);
    assign rval_nxt = rd_done ? rd_word : rval_r;
    // Reload refused during an access so a write is never cut short
    assign recfg_nxt = port.reconfig && idle && !busy_r;

    always_comb begin
        state_nxt = state_r;
        if (take_rd) begin
            state_nxt = RUSP_READ;
        end else if (take_wr) begin
            state_nxt = RUSP_WRITE;
        end else if (done) begin
            state_nxt = RUSP_IDLE;
        end
    end

    // Restart is honoured in every state, busy or not
    always_comb begin
        wdog_nxt = wdog_r;
        wexp_nxt = wexp_r;
        if (port.reset_timer) begin
            wdog_nxt = '0;
            wexp_nxt = 1'b0;
        end else if (I_WDOG_EN && !wexp_r) begin
            wdog_nxt = wdog_r + 1'b1;
            wexp_nxt = &wdog_r;
        end
    end

    // ========================================
    // Registers
    // Async reset drops any access in flight; a half-done write is lost
    always_ff @(posedge I_CLK or posedge port.reset) begin
        if (port.reset) begin
            state_r <= RUSP_IDLE;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            busy_r <= busy_nxt;
        end
    end

    always_ff @(posedge I_CLK or posedge port.reset) begin
        if (port.reset) begin
            cnt_r <= CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge I_CLK or posedge port.reset) begin
        if (port.reset) begin
            sel_r <= SEL_STATUS;
            val_r <= VAL_ZERO;
        end else begin
            sel_r <= sel_nxt;
            val_r <= val_nxt;
        end
    end

    always_ff @(posedge I_CLK or posedge port.reset) begin
        if (port.reset) begin
            rval_r <= VAL_ZERO;
        end else begin
            rval_r <= rval_nxt;
        end
    end

    // One word per index; index zero is kept but never written
    for (genvar g = 0; g < NSET; g++) begin : g_store
        always_ff @(posedge I_CLK or posedge port.reset) begin
            if (port.reset) begin
                set_r[g] <= VAL_ZERO;
            end else if (wr_done && (sel_r == SEL_W'(g))) begin
                set_r[g] <= val_r;
            end
        end
    end

    // Cause is sampled every cycle; zero out of reset as at power-up
    always_ff @(posedge I_CLK or posedge port.reset) begin
        if (port.reset) begin
            stat_r <= STAT_ZERO;
        end else begin
            stat_r <= I_CAUSE;
        end
    end

    always_ff @(posedge I_CLK or posedge port.reset) begin
        if (port.reset) begin
            recfg_r <= 1'b0;
        end else begin
            recfg_r <= recfg_nxt;
        end
    end

    always_ff @(posedge I_CLK or posedge port.reset) begin
        if (port.reset) begin
            wdog_r <= '0;
            wexp_r <= 1'b0;
        end else begin
            wdog_r <= wdog_nxt;
            wexp_r <= wexp_nxt;
        end
    end

    assign port.busy = busy_r;
    assign port.rval = rval_r;
    assign O_RECONFIG = recfg_r;
    assign O_WDOG_EXPIRE = wexp_r;
    assign O_WDOG_CNT = wdog_r;
endmodule

// >>> logic/rusp_pkg.sv
// Package: constants and types shared by the setting port and its controller
package rusp_pkg;
    localparam int SEL_W = 3;
    localparam int VAL_W = 12;
    localparam int STAT_W = 5;
    localparam int NSET = 8;
    localparam logic [SEL_W-1:0] SEL_STATUS = 3'h0;
    localparam logic [VAL_W-1:0] VAL_ZERO = 12'h000;
    localparam logic [STAT_W-1:0] STAT_ZERO = 5'h00;
    // Cycles an access keeps busy high (models the serial protocol time)
    localparam int ACC_CYC = 4;
    localparam logic [3:0] ACC_LAST = 4'h3;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    // APB register offsets of the controller
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_WDATA = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_RDATA = 8'h0C;
    // Command register bit positions
    localparam int CMD_RD = 0;
    localparam int CMD_WR = 1;
    localparam int CMD_RECFG = 2;
    localparam int CMD_WDOG = 3;
    localparam int CMD_SEL_LO = 4;
    localparam int DATA_W = 32;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    typedef enum logic [1:0] {
        RUSP_IDLE = 2'b00,
        RUSP_READ = 2'b01,
        RUSP_WRITE = 2'b10
    } rusp_state_t;
endpackage

// >>> logic/rusp_if.sv
// Interface: setting port between controller and device end
`timescale 1ns/1ns
interface rusp_if;
    import rusp_pkg::*;
    logic reset;
    logic reconfig;
    logic reset_timer;
    logic read_req;
    logic write_req;
    logic [SEL_W-1:0] sel;
    logic [VAL_W-1:0] wval;
    logic busy;
    logic [VAL_W-1:0] rval;
    modport dev (
        input reset, reconfig, reset_timer, read_req, write_req, sel, wval,
        output busy, rval
    );
    modport ctl (
        output reset, reconfig, reset_timer, read_req, write_req, sel, wval,
        input busy, rval
    );
endinterface

// >>> logic/rusp_ctl.sv
// Controller end: APB registers driving the setting port
`timescale 1ns/1ns
module rusp_ctl (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_SRST,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [rusp_pkg::DATA_W-1:0] I_PWDATA,
    output logic [rusp_pkg::DATA_W-1:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Setting port
    rusp_if.ctl port
);
    import rusp_pkg::*;

    // ========================================
    // APB decode
    wire logic acc = I_PSEL && I_PENABLE && O_PREADY;
    wire logic wr = acc && I_PWRITE;
    wire logic hit_cmd = (I_PADDR == OFS_CMD);
    wire logic hit_wd = (I_PADDR == OFS_WDATA);
    wire logic hit_st = (I_PADDR == OFS_STAT);
    wire logic hit_rd = (I_PADDR == OFS_RDATA);
    wire logic hit = hit_cmd || hit_wd || hit_st || hit_rd;
    wire logic setup = I_PSEL && !I_PENABLE;

    logic rst_r, rcf_r, rtm_r, rdq_r, wrq_r, ready_r, err_r, done_r, busy_d;
    logic [SEL_W-1:0] sel_r;
    logic [VAL_W-1:0] wval_r;
    logic [DATA_W-1:0] prdata_r;
    wire logic [DATA_W-1:0] rd_mux =
        hit_cmd ? {{(DATA_W-CMD_SEL_LO-SEL_W){1'b0}}, sel_r, 4'h0} :
        hit_wd ? {{(DATA_W-VAL_W){1'b0}}, wval_r} :
        hit_st ? {{(DATA_W-2){1'b0}}, done_r, port.busy} :
        hit_rd ? {{(DATA_W-VAL_W){1'b0}}, port.rval} : WORD_ZERO;
    // Reads and writes held off while busy so the device never sees overlap
    wire logic go = wr && hit_cmd && !port.busy && !rdq_r && !wrq_r;

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            rst_r <= 1'b1;
            rcf_r <= 1'b0;
            rtm_r <= 1'b0;
            rdq_r <= 1'b0;
            wrq_r <= 1'b0;
            sel_r <= SEL_STATUS;
            wval_r <= VAL_ZERO;
            ready_r <= 1'b0;
            err_r <= 1'b0;
            prdata_r <= WORD_ZERO;
            done_r <= 1'b0;
            busy_d <= 1'b0;
        end else begin
            rst_r <= 1'b0;
            busy_d <= port.busy;
            ready_r <= setup;
            err_r <= setup && !hit;
            if (setup) begin
                prdata_r <= rd_mux;
            end
            rdq_r <= go && I_PWDATA[CMD_RD];
            wrq_r <= go && I_PWDATA[CMD_WR] && !I_PWDATA[CMD_RD];
            // Reload passes even while busy; the device end does the refusing
            rcf_r <= wr && hit_cmd && I_PWDATA[CMD_RECFG];
            rtm_r <= wr && hit_cmd && I_PWDATA[CMD_WDOG];
            if (go) begin
                sel_r <= I_PWDATA[CMD_SEL_LO +: SEL_W];
            end
            // Free to change while busy; the device latched its copy at the request
            if (wr && hit_wd) begin
                wval_r <= I_PWDATA[VAL_W-1:0];
            end
            // Set wins over clear by software
            if (busy_d && !port.busy) begin
                done_r <= 1'b1;
            end else if (go) begin
                done_r <= 1'b0;
            end
        end
    end

    assign O_PRDATA = prdata_r;
    assign O_PREADY = ready_r;
    assign O_PSLVERR = err_r;
    assign port.reset = rst_r;
    assign port.reconfig = rcf_r;
    assign port.reset_timer = rtm_r;
    assign port.read_req = rdq_r;
    assign port.write_req = wrq_r;
    assign port.sel = sel_r;
    assign port.wval = wval_r;
endmodule

// >>> dv/rusp_assertions.sv
// Checker: handshake properties of the setting port
`timescale 1ns/1ns
module rusp_assertions
    import rusp_pkg::*;
(
    // Setting port
    input wire logic I_CLK,
    input wire logic reset,
    input wire logic read_req,
    input wire logic write_req,
    input wire logic [SEL_W-1:0] sel,
    input wire logic busy,
    input wire logic [VAL_W-1:0] rval
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (reset);
    // ========================================
    // Access sequences
    sequence s_acc;
        busy [*3] ##[1:2] !busy;
    endsequence
    sequence s_rd0;
        !busy && read_req && sel == SEL_STATUS;
    endsequence
    // ========================================
    // Properties
    rd_busy_a: assert property (!busy && read_req |=> busy)
        else $error("read not taken");
    busy_len_a: assert property ($rose(busy) |-> s_acc)
        else $error("busy length wrong");
    no_spur_a: assert property (!busy && !read_req && !write_req |=> !busy)
        else $error("busy without request");
    rval_hold_a: assert property (!busy && !$fell(busy) |-> $stable(rval))
        else $error("read value moved while idle");
    stat_rd_a: assert property (s_rd0 |=> s_acc ##0 (rval >> STAT_W) == VAL_ZERO)
        else $error("status read too wide");
    rst_idle_a: assert property ($fell(reset) |-> !busy)
        else $error("busy after reset");
    req_idle_a: assert property (busy |-> !read_req && !write_req)
        else $error("request while busy");
    wr_pulse_a: assert property (write_req |=> !write_req)
        else $error("write request too long");
endmodule

// >>> dv/tb_top.sv
// Testbench: APB-driven controller joined to the device end
`timescale 1ns/1ns
module tb_top;
    import rusp_pkg::*;
    logic clk, srst, psel, pen, pwr, fac, wden, rdy, err, lerr, rcf, wexp;
    logic [7:0] padr;
    logic [31:0] pwd, prd, rd;
    logic [4:0] cause;
    logic [3:0] wcnt;
    int failures = 0;
    int compares = 0;
    int nrc = 0;
    rusp_if port_if();
    rusp_ctl i_rusp_ctl (.I_CLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd), .O_PRDATA(prd),
        .O_PREADY(rdy), .O_PSLVERR(err), .port(port_if));
    // Short watchdog keeps the expiry wait brief
    rusp_dev #(.WDOG_W(4)) i_rusp_dev (.I_CLK(clk), .port(port_if), .I_FACTORY(fac),
        .I_CAUSE(cause), .I_WDOG_EN(wden), .O_RECONFIG(rcf), .O_WDOG_EXPIRE(wexp),
        .O_WDOG_CNT(wcnt));
    rusp_assertions i_rusp_assertions (.I_CLK(clk), .reset(port_if.reset),
        .read_req(port_if.read_req), .write_req(port_if.write_req),
        .sel(port_if.sel), .busy(port_if.busy), .rval(port_if.rval));
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rcf === 1'b1) nrc++;
    end
    // ========================================
    // Bus tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        lerr = err;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic op(input logic [31:0] c);
        int n = 0;
        apb(1, OFS_CMD, c);
        do begin
            apb(0, OFS_STAT, 0);
            n++;
        end while (rd[1:0] !== 2'b10 && n < 20);
        chk({30'h0, rd[1:0]}, 32'h0000_0002);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("Compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish;
    end
    // ========================================
    // Tests
    initial begin
        srst = 1;
        psel = 0;
        pen = 0;
        pwr = 0;
        padr = 0;
        pwd = 0;
        fac = 1;
        wden = 0;
        cause = 5'h15;
        repeat (3) @(posedge clk);
        srst <= 0;
        apb(0, OFS_STAT, 0);
        chk(rd, 0);
        for (int i = 1; i < NSET; i++) begin
            apb(1, OFS_WDATA, 32'hFFFF_F000 | (i * 32'h111));
            op({25'h0, i[2:0], 4'h2});
        end
        for (int i = 0; i < NSET; i++) begin
            op({25'h0, i[2:0], 4'h1});
            apb(0, OFS_RDATA, 0);
            chk(rd, (i == 0) ? 32'h015 : i * 32'h111);
        end
        apb(1, OFS_WDATA, 32'h0AAA);
        op(32'h0000_0003);
        apb(0, OFS_RDATA, 0);
        chk(rd, 32'h015);
        op(32'h0000_0013);
        apb(0, OFS_RDATA, 0);
        chk(rd, 32'h111);
        // Value must be taken at the request, not when busy ends
        apb(1, OFS_WDATA, 32'h0123);
        apb(1, OFS_CMD, 32'h0000_0022);
        apb(1, OFS_WDATA, 32'h0456);
        op(32'h0000_0021);
        apb(0, OFS_RDATA, 0);
        chk(rd, 32'h123);
        fac <= 0;
        apb(1, OFS_CMD, 32'h0000_0032);
        apb(0, OFS_STAT, 0);
        chk({31'h0, rd[0]}, 0);
        fac <= 1;
        op(32'h0000_0031);
        apb(0, OFS_RDATA, 0);
        chk(rd, 32'h333);
        apb(1, OFS_CMD, 32'h0000_0004);
        repeat (4) @(posedge clk);
        chk(nrc, 1);
        apb(1, OFS_CMD, 32'h0000_0011);
        op(32'h0000_0004);
        chk(nrc, 1);
        wden <= 1;
        repeat (40) @(posedge clk);
        chk({31'h0, wexp}, 1);
        apb(1, OFS_CMD, 32'h0000_0011);
        apb(1, OFS_CMD, 32'h0000_0008);
        repeat (3) @(posedge clk);
        chk({31'h0, wexp}, 0);
        chk({28'h0, wcnt}, 32'h0000_0001);
        wden <= 0;
        apb(0, 8'h10, 0);
        chk({31'h0, lerr}, 1);
        apb(1, OFS_WDATA, 32'h07AB);
        apb(1, OFS_CMD, 32'h0000_0052);
        @(posedge clk);
        srst <= 1;
        @(posedge clk);
        srst <= 0;
        apb(0, OFS_STAT, 0);
        chk(rd, 0);
        op(32'h0000_0051);
        apb(0, OFS_RDATA, 0);
        chk(rd, 0);
        tally_and_finish;
    end
endmodule
